// ==== rng_gate_pkg.sv ====
package rng_gate_pkg;
	// total failure: this many equal raw bits in a row
	localparam int TF_RUN = 8;
	localparam int RUN_W = 4;
	// online monobit test window and accepted ones count
	localparam int WIN_BITS = 256;
	localparam int WIN_W = 9;
	localparam logic [WIN_W-1:0] MONO_LO = 9'h060;
	localparam logic [WIN_W-1:0] MONO_HI = 9'h0A0;
	// periodic mode tests one window out of this many
	localparam int PERIOD_WIN = 4;
	localparam int PER_W = 2;
	localparam int OCT_W = 8;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_STARTUP = 4'b0010,
		ST_RUN = 4'b0100,
		ST_FAILED = 4'b1000
	} gate_state_t;
endpackage

// ==== health_if.sv ====
`timescale 1ns/1ps
interface health_if;
	logic bitIn;
	logic bitValid;
	logic clear;
	logic totalFail;
	logic winDone;
	logic winPass;
	modport mon (input bitIn, bitValid, clear,
		output totalFail, winDone, winPass);
	modport ctl (output bitIn, bitValid, clear,
		input totalFail, winDone, winPass);
endinterface

// ==== health_monitor.sv ====
`timescale 1ns/1ps
module health_monitor import rng_gate_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// monitor side of the health link
	health_if.mon hl
);
	logic [RUN_W-1:0] runCnt_r, runCnt_nxt;
	logic lastBit_r, lastBit_nxt;
	logic [WIN_W-1:0] ones_r, ones_nxt;
	logic [WIN_W-1:0] bitCnt_r, bitCnt_nxt;
	logic tf_r, tf_nxt, done_r, done_nxt, pass_r, pass_nxt;
	logic [WIN_W-1:0] onesNew;

	// repetition count and monobit window, both every raw bit
	always_comb begin
		runCnt_nxt = runCnt_r;
		lastBit_nxt = lastBit_r;
		ones_nxt = ones_r;
		bitCnt_nxt = bitCnt_r;
		tf_nxt = 1'b0;
		done_nxt = 1'b0;
		pass_nxt = pass_r;
		onesNew = ones_r + {{(WIN_W-1){1'b0}}, hl.bitIn};
		if (hl.clear) begin
			runCnt_nxt = '0;
			ones_nxt = '0;
			bitCnt_nxt = '0;
		end else if (hl.bitValid) begin
			lastBit_nxt = hl.bitIn;
			// a stuck source shows as a long run of one value
			if (hl.bitIn == lastBit_r && runCnt_r != '0) begin
				if (runCnt_r == RUN_W'(TF_RUN - 1))
					tf_nxt = 1'b1;
				else
					runCnt_nxt = runCnt_r + 1'b1;
			end else begin
				runCnt_nxt = RUN_W'(1);
			end
			if (bitCnt_r == WIN_W'(WIN_BITS - 1)) begin
				done_nxt = 1'b1;
				pass_nxt = onesNew >= MONO_LO && onesNew <= MONO_HI;
				ones_nxt = '0;
				bitCnt_nxt = '0;
			end else begin
				ones_nxt = onesNew;
				bitCnt_nxt = bitCnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			runCnt_r <= '0;
			lastBit_r <= 1'b0;
			ones_r <= '0;
			bitCnt_r <= '0;
			tf_r <= 1'b0;
			done_r <= 1'b0;
			pass_r <= 1'b0;
		end else begin
			runCnt_r <= runCnt_nxt;
			lastBit_r <= lastBit_nxt;
			ones_r <= ones_nxt;
			bitCnt_r <= bitCnt_nxt;
			tf_r <= tf_nxt;
			done_r <= done_nxt;
			pass_r <= pass_nxt;
		end
	end

	assign hl.totalFail = tf_r;
	assign hl.winDone = done_r;
	assign hl.winPass = pass_r;
endmodule

// ==== rng_health_gate.sv ====
`timescale 1ns/1ps
module rng_health_gate import rng_gate_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// raw entropy stream
	input wire logic rawBit,
	input wire logic rawValid,
	// software control
	input wire logic genEnable,
	input wire logic contMode,
	input wire logic selfTestStart,
	// random output
	output logic [OCT_W-1:0] rndOctet,
	output logic rndValid,
	// status
	output logic genReady,
	output logic failFlag,
	output logic defectFlag,
	output logic selfTestDone,
	output logic selfTestPass
);
	health_if hl();

	gate_state_t state_r, state_nxt;
	logic [OCT_W-1:0] shift_r, shift_nxt;
	logic [2:0] bitPos_r, bitPos_nxt;
	logic [OCT_W-1:0] held_r, held_nxt;
	logic heldValid_r, heldValid_nxt;
	logic [OCT_W-1:0] out_r, out_nxt;
	logic outValid_r, outValid_nxt;
	logic fail_r, fail_nxt, defect_r, defect_nxt;
	logic [PER_W-1:0] perCnt_r, perCnt_nxt;
	logic stPend_r, stPend_nxt, stDone_r, stDone_nxt;
	logic stPass_r, stPass_nxt;
	logic testThis, octetDone, active;

	health_monitor health_monitor_i (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.hl(hl)
	);

	// monitor is cleared whenever the generator is stopped
	assign hl.bitIn = rawBit;
	assign hl.bitValid = rawValid;
	assign hl.clear = state_r == ST_IDLE;

	// main gate state and health verdicts
	always_comb begin
		state_nxt = state_r;
		fail_nxt = fail_r;
		defect_nxt = defect_r;
		perCnt_nxt = perCnt_r;
		// start-up window is always judged; later ones per mode
		testThis = state_r == ST_STARTUP || contMode ||
			perCnt_r == '0;
		active = state_r == ST_STARTUP || state_r == ST_RUN;
		if (!genEnable) begin
			// restart is the only way out of a failure
			state_nxt = ST_IDLE;
			fail_nxt = 1'b0;
			defect_nxt = 1'b0;
			perCnt_nxt = '0;
		end else begin
			unique case (state_r)
			ST_IDLE: state_nxt = ST_STARTUP;
			ST_STARTUP, ST_RUN: begin
				if (hl.winDone && state_r == ST_RUN)
					perCnt_nxt = perCnt_r + 1'b1;
				if (hl.totalFail) begin
					fail_nxt = 1'b1;
					state_nxt = ST_FAILED;
				end else if (hl.winDone && testThis) begin
					if (!hl.winPass) begin
						defect_nxt = 1'b1;
						state_nxt = ST_FAILED;
					end else if (state_r == ST_STARTUP) begin
						state_nxt = ST_RUN;
					end
				end
			end
			ST_FAILED: state_nxt = ST_FAILED;
			endcase
		end
	end

	// octet assembly with one octet held back, so a failure
	// found late still catches the bits just before it
	always_comb begin
		shift_nxt = shift_r;
		bitPos_nxt = bitPos_r;
		held_nxt = held_r;
		heldValid_nxt = heldValid_r;
		out_nxt = out_r;
		outValid_nxt = 1'b0;
		octetDone = rawValid && bitPos_r == 3'h7;
		if (state_r != ST_RUN || state_nxt != ST_RUN) begin
			bitPos_nxt = '0;
			heldValid_nxt = 1'b0;
		end else if (rawValid) begin
			shift_nxt = {shift_r[OCT_W-2:0], rawBit};
			bitPos_nxt = bitPos_r + 1'b1;
			if (octetDone) begin
				held_nxt = {shift_r[OCT_W-2:0], rawBit};
				heldValid_nxt = 1'b1;
				if (heldValid_r) begin
					out_nxt = held_r;
					outValid_nxt = 1'b1;
				end
			end
		end
	end

	// software self-test: judged on the window that ends next, even one already under way
	always_comb begin
		stPend_nxt = stPend_r;
		stDone_nxt = stDone_r;
		stPass_nxt = stPass_r;
		if (selfTestStart) begin
			stDone_nxt = 1'b0;
			stPass_nxt = 1'b0;
			if (active) begin
				stPend_nxt = 1'b1;
			end else if (state_r == ST_FAILED) begin
				stDone_nxt = 1'b1;
			end
		end else if (stPend_r) begin
			if (!genEnable || hl.totalFail) begin
				stPend_nxt = 1'b0;
				stDone_nxt = 1'b1;
				stPass_nxt = 1'b0;
			end else if (hl.winDone) begin
				stPend_nxt = 1'b0;
				stDone_nxt = 1'b1;
				stPass_nxt = hl.winPass && !fail_r && !defect_r;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_IDLE;
			fail_r <= 1'b0;
			defect_r <= 1'b0;
			perCnt_r <= '0;
			shift_r <= '0;
			bitPos_r <= '0;
			held_r <= '0;
			heldValid_r <= 1'b0;
			out_r <= '0;
			outValid_r <= 1'b0;
			stPend_r <= 1'b0;
			stDone_r <= 1'b0;
			stPass_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			fail_r <= fail_nxt;
			defect_r <= defect_nxt;
			perCnt_r <= perCnt_nxt;
			shift_r <= shift_nxt;
			bitPos_r <= bitPos_nxt;
			held_r <= held_nxt;
			heldValid_r <= heldValid_nxt;
			out_r <= out_nxt;
			outValid_r <= outValid_nxt;
			stPend_r <= stPend_nxt;
			stDone_r <= stDone_nxt;
			stPass_r <= stPass_nxt;
		end
	end

	// outputs straight from flops; ready is the run state bit
	assign rndOctet = out_r;
	assign rndValid = outValid_r;
	assign genReady = state_r[2];
	assign failFlag = fail_r;
	assign defectFlag = defect_r;
	assign selfTestDone = stDone_r;
	assign selfTestPass = stPass_r;

	// checks
	a_fail_blocks: assert property (@(posedge ref_clk) disable iff (!arst_n)
		failFlag |-> !rndValid)
		else $error("octet released after total failure");
	a_fail_drops: assert property (@(posedge ref_clk) disable iff (!arst_n)
		hl.totalFail && genEnable && active |=> !rndValid[*8])
		else $error("octet released right after failure");
	a_defect_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
		genEnable && active && hl.winDone && testThis && !hl.winPass
		&& !hl.totalFail |=> defectFlag && !genReady)
		else $error("failed window not flagged");
	a_startup_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
		rndValid |-> $past(state_r, 1) == ST_RUN)
		else $error("octet before start-up pass");
	a_cont_mode: assert property (@(posedge ref_clk) disable iff (!arst_n)
		contMode && genEnable && state_r == ST_RUN && hl.winDone
		&& !hl.winPass |=> state_r == ST_FAILED)
		else $error("continuous mode missed a bad window");
	a_selftest_done: assert property (@(posedge ref_clk) disable iff (!arst_n)
		stPend_r && !selfTestStart && genEnable && !hl.totalFail
		&& hl.winDone |=> selfTestDone
		&& (selfTestPass == $past(hl.winPass && !fail_r && !defect_r)))
		else $error("self-test verdict wrong");
	// a stop or a stuck source while pending must read as a fail
	a_selftest_abort: assert property (@(posedge ref_clk) disable iff (!arst_n)
		stPend_r && !selfTestStart && (!genEnable || hl.totalFail)
		|=> selfTestDone && !selfTestPass)
		else $error("aborted self-test not failed");
	a_sticky_fail: assert property (@(posedge ref_clk) disable iff (!arst_n)
		failFlag && genEnable |=> failFlag)
		else $error("failure flag dropped while enabled");
	a_valid_blocked: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!genReady |=> !rndValid)
		else $error("valid while blocked");
	a_restart_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!genEnable |=> !failFlag && !defectFlag && state_r == ST_IDLE)
		else $error("restart did not clear flags");

	c_octet_out: cover property (@(posedge ref_clk) disable iff (!arst_n)
		rndValid);
	c_total_fail: cover property (@(posedge ref_clk) disable iff (!arst_n)
		$rose(failFlag));
	c_defect: cover property (@(posedge ref_clk) disable iff (!arst_n)
		$rose(defectFlag));
	c_selftest_pass: cover property (@(posedge ref_clk) disable iff (!arst_n)
		$rose(selfTestDone) && selfTestPass);
endmodule

// ==== rng_health_gate_test.sv ====
`timescale 1ns/1ps
module rng_health_gate_test import rng_gate_pkg::*;;
	logic ref_clk, arst_n, rawBit, rawValid, genEnable, contMode;
	logic selfTestStart, rndValid, genReady, failFlag, defectFlag;
	logic selfTestDone, selfTestPass;
	logic [OCT_W-1:0] rndOctet, lastOct;
	int n_errors, check_count, nRel, n0, cycles;

	// clock, inputs settled at time zero
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	rng_health_gate rng_health_gate_i (.ref_clk(ref_clk), .arst_n(arst_n),
		.rawBit(rawBit), .rawValid(rawValid), .genEnable(genEnable),
		.contMode(contMode), .selfTestStart(selfTestStart),
		.rndOctet(rndOctet), .rndValid(rndValid), .genReady(genReady),
		.failFlag(failFlag), .defectFlag(defectFlag),
		.selfTestDone(selfTestDone), .selfTestPass(selfTestPass));

	// release log and hang guard; run needs about 2500 cycles
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (rndValid === 1'b1) begin
			nRel <= nRel + 1;
			lastOct <= rndOctet;
		end
		if (cycles == 20000) begin
			n_errors = n_errors + 1;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (n_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// msb first, one bit per edge, strobe held high
	task automatic sendByte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			@(posedge ref_clk);
			rawBit <= b[i];
			rawValid <= 1'b1;
		end
	endtask

	task automatic sendRep(input logic [7:0] b, input int n);
		repeat (n) sendByte(b);
		@(posedge ref_clk);
		rawValid <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask

	task automatic restart(input logic cm);
		@(posedge ref_clk);
		genEnable <= 1'b0;
		contMode <= cm;
		repeat (2) @(posedge ref_clk);
		genEnable <= 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		n0 = nRel;
	endtask

	task automatic pulseSelf();
		@(posedge ref_clk);
		selfTestStart <= 1'b1;
		@(posedge ref_clk);
		selfTestStart <= 1'b0;
	endtask

	task automatic testStartup();
		restart(1'b0);
		sendRep(8'hAA, 32);
		chk("genReady", 8'h01, {7'h00, genReady});
		chk("early octets", 8'h00, 8'(nRel - n0));
		sendByte(8'hA5);
		sendRep(8'h3C, 1);
		chk("octets", 8'h01, 8'(nRel - n0));
		chk("octet msb first", 8'hA5, lastOct);
	endtask

	task automatic testSelf();
		n0 = nRel;
		pulseSelf();
		sendRep(8'hAA, 33);
		chk("selftest done", 8'h01, {7'h00, selfTestDone});
		chk("selftest pass", 8'h01, {7'h00, selfTestPass});
		chk("run octets", 8'h21, 8'(nRel - n0));
	endtask

	// a run of eight ones inside the second octet; only the held one escapes
	task automatic testFail();
		n0 = nRel;
		pulseSelf();
		sendByte(8'h55);
		sendRep(8'hFF, 1);
		sendRep(8'hAA, 4);
		chk("failFlag", 8'h01, {7'h00, failFlag});
		chk("genReady", 8'h00, {7'h00, genReady});
		chk("octets after fail", 8'h01, 8'(nRel - n0));
		chk("abort done", 8'h01, {7'h00, selfTestDone});
		pulseSelf();
		repeat (3) @(posedge ref_clk);
		#1;
		chk("failed done", 8'h01, {7'h00, selfTestDone});
		chk("failed pass", 8'h00, {7'h00, selfTestPass});
		repeat (20) @(posedge ref_clk);
		#1;
		chk("fail sticky", 8'h01, {7'h00, failFlag});
		restart(1'b1);
		chk("fail cleared", 8'h00, {7'h00, failFlag});
	endtask

	// 224 ones per window, runs never reach eight
	task automatic testDefect();
		sendRep(8'hFE, 32);
		chk("startup defect", 8'h01, {7'h00, defectFlag});
		chk("no ready", 8'h00, {7'h00, genReady});
		sendRep(8'hAA, 4);
		chk("blocked octets", 8'h00, 8'(nRel - n0));
		restart(1'b1);
		sendRep(8'hAA, 32);
		chk("ready cont", 8'h01, {7'h00, genReady});
		sendRep(8'hFE, 64);
		chk("run defect", 8'h01, {7'h00, defectFlag});
		chk("run blocked", 8'h00, {7'h00, genReady});
	endtask

	// periodic mode judges run window 1, skips window 2
	task automatic testPeriodic();
		restart(1'b0);
		sendRep(8'hAA, 64);
		chk("per ready", 8'h01, {7'h00, genReady});
		sendRep(8'hFE, 32);
		chk("skipped window", 8'h00, {7'h00, defectFlag});
		chk("still ready", 8'h01, {7'h00, genReady});
	endtask

	// main sequence
	initial begin
		{arst_n, rawBit, rawValid, genEnable, contMode, selfTestStart} = '0;
		{n_errors, check_count, nRel, cycles} = '0;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("reset outs", 8'h00,
			{rndValid, genReady, failFlag, defectFlag,
			selfTestDone, selfTestPass, 2'b00});
		@(posedge ref_clk);
		arst_n <= 1'b1;
		testStartup();
		testSelf();
		testFail();
		testDefect();
		testPeriodic();
		give_verdict();
	end
endmodule
